// File: hw/amcfg_defines.svh
`ifndef AMCFG_DEFINES_SVH
`define AMCFG_DEFINES_SVH
// configuration memory byte addresses
`define AMCFG_ADDR_UDMA 8'h06
`define AMCFG_ADDR_PIO 8'h07
`define AMCFG_ADDR_PIN 8'h08
// byte 0x06 fields
`define AMCFG_UDMA_ATA_BIT 7
`define AMCFG_UDMA_ATAPI_BIT 6
`define AMCFG_UDMA_M4_BIT 4
`define AMCFG_UDMA_M2_BIT 2
`define AMCFG_UDMA_RSVD_MASK 8'h2B
// byte 0x07 fields
`define AMCFG_MWDMA_BIT 2
`define AMCFG_PIO4_BIT 1
`define AMCFG_PIO3_BIT 0
`define AMCFG_PIO_RSVD_MASK 8'hF8
// byte 0x08 fields
`define AMCFG_BUTTON_BIT 7
`define AMCFG_SEARCH_BIT 6
`define AMCFG_PKG_BIT 5
`define AMCFG_SHARE_BIT 4
`define AMCFG_RDYPOL_BIT 3
`define AMCFG_HSIND_BIT 2
`define AMCFG_PVPOL_BIT 1
`define AMCFG_PVEN_BIT 0
// reset values until loaded
`define AMCFG_RST_UDMA 8'h00
`define AMCFG_RST_PIO 8'h00
`define AMCFG_RST_PIN 8'h00
// mode encodings
`define AMCFG_UDMA_NONE 2'h0
`define AMCFG_UDMA_2 2'h1
`define AMCFG_UDMA_4 2'h2
`define AMCFG_PIO_0 2'h0
`define AMCFG_PIO_3 2'h1
`define AMCFG_PIO_4 2'h2
`endif

// File: hw/amcfg_pkg.sv
`default_nettype none
package amcfg_pkg;
   typedef enum {AMCFG_IDLE, AMCFG_LOAD, AMCFG_DONE} amcfg_state_t;
endpackage
`default_nettype wire

// File: hw/amcfg_mode_pick.sv
`include "amcfg_defines.svh"
`default_nettype none
module amcfg_mode_pick
   import amcfg_pkg::*;
(
   input wire logic [7:0] udma_cfg,
   input wire logic [7:0] pio_cfg,
   input wire logic is_atapi,
   input wire logic [4:0] drv_udma_sup,
   input wire logic drv_mwdma_sup,
   input wire logic [4:0] drv_pio_sup,
   output logic udma_use,
   output logic [1:0] udma_mode,
   output logic mwdma_use,
   output logic [1:0] pio_mode
);
   logic udma_allowed;
   always_comb begin
      udma_allowed = is_atapi ? udma_cfg[`AMCFG_UDMA_ATAPI_BIT]
         : udma_cfg[`AMCFG_UDMA_ATA_BIT];
      // highest common mode wins
      if (udma_allowed && udma_cfg[`AMCFG_UDMA_M4_BIT] && drv_udma_sup[4]) begin
         udma_mode = `AMCFG_UDMA_4;
      end else if (udma_allowed && udma_cfg[`AMCFG_UDMA_M2_BIT] && drv_udma_sup[2]) begin
         udma_mode = `AMCFG_UDMA_2;
      end else begin
         udma_mode = `AMCFG_UDMA_NONE;
      end
      udma_use = (udma_mode != `AMCFG_UDMA_NONE);
      mwdma_use = pio_cfg[`AMCFG_MWDMA_BIT] && drv_mwdma_sup;
      if (pio_cfg[`AMCFG_PIO4_BIT] && drv_pio_sup[4]) begin
         pio_mode = `AMCFG_PIO_4;
      end else if (pio_cfg[`AMCFG_PIO3_BIT] && drv_pio_sup[3]) begin
         pio_mode = `AMCFG_PIO_3;
      end else begin
         pio_mode = `AMCFG_PIO_0;
      end
   end
endmodule
`default_nettype wire

// File: hw/amcfg_top.sv
`include "amcfg_defines.svh"
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Contract
// - byte 6 bit 7 allows ultra DMA with ATA drives.
// - byte 6 bit 6 allows ultra DMA with ATAPI drives reporting support.
// - run highest enabled ultra DMA mode the drive supports.
// - byte 7 bit 2 with drive support selects multiword DMA.
// - byte 7 bits 1,0 enable PIO 4 and 3; highest supported used.
// - PIO mode 0 is always enabled.
// - byte 8 bit 7 turns three pins into buttons on endpoint one IN bits.
// - byte 8 bit 6 enables fixed drive search at reset.
// - sharing input low: drive bus if byte 8 bit 4 else Hi-Z.
// - byte 8 bit 3 sets disk ready pin active level.
// - byte 8 bit 1 sets drive power valid input polarity.
// - byte 8 bit 0 enables power valid pin unless byte 8 bit 7 is set, removable drive as master.
module amcfg_top
   import amcfg_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic cfg_wr,
   input wire logic [7:0] cfg_addr,
   input wire logic [7:0] cfg_data,
   input wire logic cfg_done,
   input wire logic is_atapi,
   input wire logic [4:0] drv_udma_sup,
   input wire logic drv_mwdma_sup,
   input wire logic [4:0] drv_pio_sup,
   input wire logic bus_share_enable_input,
   input wire logic disk_ready,
   input wire logic high_speed,
   input wire logic gpio2_out,
   input wire logic gpio2_oe,
   input wire logic bus_pullup_enable_pin,
   input wire logic high_power_request_pin,
   input wire logic drive_power_valid_pin,
   output logic cfg_valid,
   output logic [7:0] transfer_udma_config,
   output logic [7:0] transfer_pio_mwdma_config,
   output logic [7:0] pin_function_config,
   output logic udma_use,
   output logic [1:0] udma_mode,
   output logic mwdma_use,
   output logic [1:0] pio_mode,
   output logic button_mode,
   output logic [2:0] endpoint_one_in_buttons,
   output logic fixed_drive_search_enable,
   output logic large_package_select,
   output logic ata_bus_drive_en,
   output logic disk_ready_pin,
   output logic speed_indicator_pin,
   output logic speed_indicator_oe,
   output logic drive_power_present,
   output logic removable_master
);
   typedef struct packed {
      amcfg_state_t state;
      logic [7:0] udma;
      logic [7:0] pio;
      logic [7:0] pin;
      logic valid;
      logic udma_use;
      logic [1:0] udma_mode;
      logic mwdma_use;
      logic [1:0] pio_mode;
      logic [2:0] buttons;
      logic bus_en;
      logic rdy;
      logic spd;
      logic spd_oe;
      logic pwr;
      logic btn;
      logic srch;
      logic pkg;
      logic rmst;
   } amcfg_regs_t;

   amcfg_regs_t r;
   amcfg_regs_t next_r;
   logic sel_udma_use;
   logic [1:0] sel_udma_mode;
   logic sel_mwdma_use;
   logic [1:0] sel_pio_mode;
   logic [7:0] live_pin;

   // a partly loaded pin byte must not steer pins before the freeze
   assign live_pin = r.valid ? r.pin : `AMCFG_RST_PIN;

   ////////////////////////////////////////////////////////////////////////////
   // a field bit under a reserved mask would be wiped on load and never work
   if (((`AMCFG_UDMA_RSVD_MASK >> `AMCFG_UDMA_ATA_BIT) & 8'h01) != 8'h00) begin : g_chk_ata
      $error("ata udma bit is masked");
   end
   if (((`AMCFG_UDMA_RSVD_MASK >> `AMCFG_UDMA_ATAPI_BIT) & 8'h01) != 8'h00) begin : g_chk_atapi
      $error("atapi udma bit is masked");
   end
   if (((`AMCFG_UDMA_RSVD_MASK >> `AMCFG_UDMA_M4_BIT) & 8'h01) != 8'h00) begin : g_chk_m4
      $error("udma mode 4 bit is masked");
   end
   if (((`AMCFG_UDMA_RSVD_MASK >> `AMCFG_UDMA_M2_BIT) & 8'h01) != 8'h00) begin : g_chk_m2
      $error("udma mode 2 bit is masked");
   end
   if (((`AMCFG_PIO_RSVD_MASK >> `AMCFG_MWDMA_BIT) & 8'h01) != 8'h00) begin : g_chk_mw
      $error("multiword dma bit is masked");
   end
   if (((`AMCFG_PIO_RSVD_MASK >> `AMCFG_PIO4_BIT) & 8'h01) != 8'h00) begin : g_chk_pio4
      $error("pio mode 4 bit is masked");
   end
   if (((`AMCFG_PIO_RSVD_MASK >> `AMCFG_PIO3_BIT) & 8'h01) != 8'h00) begin : g_chk_pio3
      $error("pio mode 3 bit is masked");
   end

   ////////////////////////////////////////////////////////////////////////////
   amcfg_mode_pick u_pick (
      .udma_cfg(r.udma),
      .pio_cfg(r.pio),
      .is_atapi(is_atapi),
      .drv_udma_sup(drv_udma_sup),
      .drv_mwdma_sup(drv_mwdma_sup),
      .drv_pio_sup(drv_pio_sup),
      .udma_use(sel_udma_use),
      .udma_mode(sel_udma_mode),
      .mwdma_use(sel_mwdma_use),
      .pio_mode(sel_pio_mode)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_r = r;
      case (r.state)
         AMCFG_IDLE: begin
            if (cfg_wr) begin
               next_r.state = AMCFG_LOAD;
            end
         end
         AMCFG_LOAD: begin
            if (cfg_done) begin
               next_r.state = AMCFG_DONE;
               next_r.valid = 1'b1;
            end
         end
         AMCFG_DONE: begin
            // frozen once loaded; only reset reopens loading
         end
         default: begin
            next_r.state = AMCFG_IDLE;
         end
      endcase
      if (cfg_wr && r.state != AMCFG_DONE) begin
         if (cfg_addr == `AMCFG_ADDR_UDMA) begin
            // reserved bits dropped so they can never pick a mode
            next_r.udma = cfg_data & ~`AMCFG_UDMA_RSVD_MASK;
         end
         if (cfg_addr == `AMCFG_ADDR_PIO) begin
            next_r.pio = cfg_data & ~`AMCFG_PIO_RSVD_MASK;
         end
         if (cfg_addr == `AMCFG_ADDR_PIN) begin
            next_r.pin = cfg_data;
         end
      end
      // drive-facing outputs stay at safe defaults until loaded
      next_r.udma_use = r.valid & sel_udma_use;
      next_r.udma_mode = r.valid ? sel_udma_mode : `AMCFG_UDMA_NONE;
      next_r.mwdma_use = r.valid & sel_mwdma_use;
      next_r.pio_mode = r.valid ? sel_pio_mode : `AMCFG_PIO_0;
      if (r.valid && r.pin[`AMCFG_BUTTON_BIT]) begin
         next_r.buttons = {bus_pullup_enable_pin, high_power_request_pin, drive_power_valid_pin};
      end else begin
         next_r.buttons = 3'h0;
      end
      next_r.bus_en = !bus_share_enable_input ? live_pin[`AMCFG_SHARE_BIT] : 1'b1;
      next_r.rdy = live_pin[`AMCFG_RDYPOL_BIT] ? disk_ready : !disk_ready;
      next_r.spd = live_pin[`AMCFG_HSIND_BIT] ? high_speed : gpio2_out;
      next_r.spd_oe = gpio2_oe;
      if (!r.valid || !r.pin[`AMCFG_PVEN_BIT] || r.pin[`AMCFG_BUTTON_BIT]) begin
         next_r.pwr = 1'b0;
      end else begin
         next_r.pwr = drive_power_valid_pin ~^ r.pin[`AMCFG_PVPOL_BIT];
      end
      // status flags rise in the same cycle as cfg_valid
      next_r.btn = next_r.valid & next_r.pin[`AMCFG_BUTTON_BIT];
      next_r.srch = next_r.valid & next_r.pin[`AMCFG_SEARCH_BIT];
      next_r.pkg = next_r.valid & next_r.pin[`AMCFG_PKG_BIT];
      next_r.rmst = next_r.valid & next_r.pin[`AMCFG_PVEN_BIT];
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         r <= '0;
         r.state <= AMCFG_IDLE;
         r.udma <= `AMCFG_RST_UDMA;
         r.pio <= `AMCFG_RST_PIO;
         r.pin <= `AMCFG_RST_PIN;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      cfg_valid = r.valid;
      transfer_udma_config = r.udma;
      transfer_pio_mwdma_config = r.pio;
      pin_function_config = r.pin;
      udma_use = r.udma_use;
      udma_mode = r.udma_mode;
      mwdma_use = r.mwdma_use;
      pio_mode = r.pio_mode;
      button_mode = r.btn;
      endpoint_one_in_buttons = r.buttons;
      fixed_drive_search_enable = r.srch;
      large_package_select = r.pkg;
      ata_bus_drive_en = r.bus_en;
      disk_ready_pin = r.rdy;
      speed_indicator_pin = r.spd;
      speed_indicator_oe = r.spd_oe;
      drive_power_present = r.pwr;
      removable_master = r.rmst;
   end
endmodule
`default_nettype wire

// File: bench/amcfg_assertions.sv
`include "amcfg_defines.svh"
`default_nettype none
module amcfg_assertions (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic cfg_valid,
   input wire logic [7:0] transfer_udma_config,
   input wire logic [7:0] transfer_pio_mwdma_config,
   input wire logic [7:0] pin_function_config,
   input wire logic [4:0] drv_udma_sup,
   input wire logic [4:0] drv_pio_sup,
   input wire logic bus_share_enable_input,
   input wire logic disk_ready,
   input wire logic drive_power_valid_pin,
   input wire logic udma_use,
   input wire logic [1:0] udma_mode,
   input wire logic [1:0] pio_mode,
   input wire logic fixed_drive_search_enable,
   input wire logic large_package_select,
   input wire logic ata_bus_drive_en,
   input wire logic disk_ready_pin,
   input wire logic drive_power_present
);
   timeunit 1ns;
   timeprecision 1ps;
   logic frz;
   logic [7:0] p;
   logic [7:0] q;
   assign p = pin_function_config;
   assign q = transfer_pio_mwdma_config;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff rst;
   // one cycle after freeze, so derived outputs have settled
   always_ff @(posedge sys_clk) frz <= rst ? 1'b0 : cfg_valid;
   ////////////////////////////////////////
   a_share_drive: assert property (
      frz |-> ata_bus_drive_en == ($past(bus_share_enable_input) | p[4]))
      else $error("bus drive wrong");
   a_ready_level: assert property (
      frz |-> disk_ready_pin == ($past(disk_ready) ~^ p[3]))
      else $error("ready level wrong");
   a_search_pkg: assert property (
      frz |-> fixed_drive_search_enable == p[6] && large_package_select == p[5])
      else $error("search or package wrong");
   a_power_valid: assert property (
      frz |-> drive_power_present == (p[0] && !p[7] && ($past(drive_power_valid_pin) ~^ p[1])))
      else $error("power valid wrong");
   a_pio_pick: assert property (
      frz |-> pio_mode == (q[1] && $past(drv_pio_sup[4]) ? `AMCFG_PIO_4 :
         q[0] && $past(drv_pio_sup[3]) ? `AMCFG_PIO_3 : `AMCFG_PIO_0))
      else $error("pio mode wrong");
   a_udma_best: assert property (
      frz && udma_use |-> udma_mode == (transfer_udma_config[4] && $past(drv_udma_sup[4])
         ? `AMCFG_UDMA_4 : `AMCFG_UDMA_2))
      else $error("udma mode wrong");
   a_rsvd_zero: assert property (
      (transfer_udma_config & 8'h2B) == 8'h00 && (q & 8'hF8) == 8'h00)
      else $error("reserved bits set");
   a_bytes_frozen: assert property (
      cfg_valid |=> cfg_valid && $stable(p) && $stable(q) && $stable(transfer_udma_config))
      else $error("bytes changed");
   c_udma_on: cover property (frz && udma_use);
   c_buttons: cover property (frz && p[7]);
   c_bus_hiz: cover property (frz && !ata_bus_drive_en);
endmodule
bind amcfg_top amcfg_assertions u_chk (.*);
`default_nettype wire

// File: bench/amcfg_eeprom_model.sv
`default_nettype none
module amcfg_eeprom_model (
   input wire logic sys_clk,
   input wire logic start,
   input wire logic [1:0] gap,
   input wire logic [23:0] image,
   output logic cfg_wr,
   output logic [7:0] cfg_addr,
   output logic [7:0] cfg_data,
   output logic cfg_done,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   // released bus inverts data each idle cycle, so an even gap shows the written byte again
   initial begin
      {cfg_wr, cfg_addr, cfg_data, cfg_done, busy} = '0;
      forever begin
         @(posedge start);
         busy = 1'b1;
         for (int i = 0; i < 3; i++) begin
            @(negedge sys_clk);
            cfg_wr = 1'b1;
            cfg_addr = 8'h06 + 8'(i);
            cfg_data = image[8*i+:8];
            repeat (gap) begin
               @(negedge sys_clk);
               cfg_wr = 1'b0;
               cfg_data = ~cfg_data;
            end
         end
         @(negedge sys_clk);
         cfg_wr = 1'b0;
         cfg_addr = ~cfg_addr;
         cfg_data = ~cfg_data;
         cfg_done = 1'b1;
         @(negedge sys_clk);
         cfg_done = 1'b0;
         busy = 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: bench/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic start = 1'b0;
   logic [1:0] gap = 2'h0;
   logic [23:0] image = 24'h0;
   logic [19:0] ins = 20'h0;
   int n_errors = 0;
   int compares = 0;
   int cycles = 0;
   logic cfg_wr, cfg_done, busy, is_atapi, drv_mwdma_sup, bus_share_enable_input, disk_ready;
   logic high_speed, gpio2_out, gpio2_oe, bus_pullup_enable_pin, high_power_request_pin;
   logic drive_power_valid_pin, cfg_valid, udma_use, mwdma_use, button_mode, speed_indicator_pin;
   logic fixed_drive_search_enable, large_package_select, ata_bus_drive_en, disk_ready_pin;
   logic speed_indicator_oe, drive_power_present, removable_master;
   logic [1:0] udma_mode, pio_mode;
   logic [2:0] endpoint_one_in_buttons;
   logic [4:0] drv_udma_sup, drv_pio_sup;
   logic [7:0] cfg_addr, cfg_data, transfer_udma_config, transfer_pio_mwdma_config;
   logic [7:0] pin_function_config, mst, pins, pvv;
   assign {is_atapi, drv_udma_sup, drv_mwdma_sup, drv_pio_sup, bus_share_enable_input, disk_ready,
      high_speed, gpio2_out, gpio2_oe, bus_pullup_enable_pin, high_power_request_pin,
      drive_power_valid_pin} = ins;
   assign mst = {1'b0, cfg_valid, udma_use, udma_mode, mwdma_use, pio_mode};
   assign pins = {button_mode, endpoint_one_in_buttons, fixed_drive_search_enable,
      large_package_select, ata_bus_drive_en, disk_ready_pin};
   assign pvv = {4'h0, speed_indicator_oe, speed_indicator_pin, drive_power_present,
      removable_master};
   amcfg_top DUT (.*);
   amcfg_eeprom_model u_eeprom (.*);
   always #4 sys_clk = ~sys_clk;
   ////////////////////////////////////////
   task automatic end_of_test();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_errors++;
         end_of_test();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // two edges: registered outputs lag their inputs
   task automatic put(input logic [19:0] v);
      @(negedge sys_clk);
      ins = v;
      repeat (2) @(negedge sys_clk);
   endtask
   task automatic load(input logic [23:0] img, input logic [1:0] g);
      @(negedge sys_clk);
      image = img;
      gap = g;
      start = 1'b1;
      @(negedge sys_clk);
      start = 1'b0;
      while (busy === 1'b1) @(negedge sys_clk);
      repeat (2) @(negedge sys_clk);
   endtask
   task automatic t_fixed_drive();
      put(20'h7DF6D);
      load(24'h7F07D4, 2'h0);
      chk(transfer_udma_config, 8'hD4);
      chk(mst, 8'h72);
      chk(pins, 8'h0F);
      chk(pvv, 8'h0F);
      put(20'h1DF6D);
      chk(mst, 8'h6A);
      put(20'h1CF6D);
      chk(mst, 8'h69);
      put(20'h1C76D);
      chk(mst, 8'h68);
      load(24'h000000, 2'h1);
      chk(pin_function_config, 8'h7F);
      $display("test fixed drive done");
   endtask
   task automatic t_removable();
      @(negedge sys_clk);
      rst = 1'b1;
      put(20'hFFF6D);
      rst = 1'b0;
      @(negedge sys_clk);
      chk(mst, 8'h00);
      chk(transfer_pio_mwdma_config, 8'h00);
      load(24'h810480, 2'h2);
      chk(mst, 8'h44);
      chk(pins, 8'hD0);
      chk(pvv, 8'h09);
      put(20'hFFFED);
      chk(pins, 8'hD2);
      $display("test removable done");
   endtask
   task automatic t_atapi_udma();
      @(negedge sys_clk);
      rst = 1'b1;
      put(20'hFFF6D);
      rst = 1'b0;
      load(24'h01FF7F, 2'h0);
      chk(transfer_udma_config, 8'h54);
      chk(transfer_pio_mwdma_config, 8'h07);
      chk(mst, 8'h76);
      chk(pins, 8'h00);
      chk(pvv, 8'h09);
      put(20'h7FF2C);
      chk(mst, 8'h46);
      chk(pins, 8'h01);
      chk(pvv, 8'h0B);
      $display("test atapi udma done");
   endtask
   initial begin
      repeat (16) @(negedge sys_clk);
      rst = 1'b0;
      t_fixed_drive();
      t_removable();
      t_atapi_udma();
      end_of_test();
   end
endmodule
`default_nettype wire
